//--- rtl/ipcb_bank.sv
// interrupt priority control bank with an axi4-lite register slave
`timescale 1ns/1ns
`include "ipcb_params.svh"
//
// Behaviour
// - 3-bit level 1..7; zero disables source
// - 2-bit sublevel equals field value 0..3
// - top three bits per byte read zero
// - slot three at bits 28:26, 25:24
// - slot two at bits 20:18, 17:16
// - slot one at bits 12:10, 9:8
// - slot zero at 4:2, 1:0; 7:5 zero
module ipcb_bank
   import ipcb_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // axi4-lite slave
   input wire logic s_awvalid_in,
   input wire logic [3:0] s_awaddr_in,
   input wire logic s_wvalid_in,
   input wire logic [31:0] s_wdata_in,
   input wire logic [3:0] s_wstrb_in,
   input wire logic s_bready_in,
   input wire logic s_arvalid_in,
   input wire logic [3:0] s_araddr_in,
   input wire logic s_rready_in,
   output logic s_awready_out,
   output logic s_wready_out,
   output logic s_bvalid_out,
   output logic [1:0] s_bresp_out,
   output logic s_arready_out,
   output logic s_rvalid_out,
   output logic [31:0] s_rdata_out,
   output logic [1:0] s_rresp_out,
   // per-slot settings for the arbiter
   output logic [3:0] slot_enabled_out,
   output logic [11:0] slot_level_out,
   output logic [7:0] slot_sublevel_out
);
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic rst_b;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_ff[1];

   // ------------------------------------------------------------
   // bus state
   // ------------------------------------------------------------
   typedef struct packed {
      logic aw_held;
      logic [3:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [3:0] en;
      logic [11:0] lvl;
      logic [7:0] sub;
      logic awready;
      logic wready;
      logic arready;
   } ipcb_bus_s;

   // readies are held as flops of their own so that every bus output comes straight from a flop
   localparam ipcb_bus_s bus_rst = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

   ipcb_bus_s st_ff;
   ipcb_bus_s nxt_st;
   ipcb_slot_s [3:0] slots;
   logic [31:0] word;
   logic wr_go;
   logic [3:0] wr_strb;

   // word select uses bits 3:2 of the byte address
   localparam logic [3:0] ctrl_addr = `IPCB_CTRL_OFFSET;
   localparam logic [3:0] status_addr = `IPCB_STATUS_OFFSET;

   ipcb_slot_store u_store (
      .clk_in(mclk_in),
      .rst_b_in(rst_b),
      .ce_in(ce_in),
      .wr_en_in(wr_go),
      .wr_data_in(st_ff.wdata),
      .wr_strb_in(wr_strb),
      .slots_out(slots),
      .rd_word_out(word)
   );

   // write fires once address and data are both held and no response is pending
   assign wr_go = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
   assign wr_strb = (st_ff.awaddr[3:2] == ctrl_addr[3:2]) ? st_ff.wstrb : 4'h0;

   always_comb begin
      nxt_st = st_ff;
      if (ce_in) begin
         if (s_awvalid_in && !st_ff.aw_held) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.awaddr = s_awaddr_in;
         end
         if (s_wvalid_in && !st_ff.w_held) begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata = s_wdata_in;
            nxt_st.wstrb = s_wstrb_in;
         end
         if (wr_go) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            // status word is read only; writes there and unmapped writes are refused
            nxt_st.bresp = (st_ff.awaddr[3:2] == ctrl_addr[3:2]) ?
                           `IPCB_RESP_OKAY : `IPCB_RESP_SLVERR;
         end
         if (st_ff.bvalid && s_bready_in) begin
            nxt_st.bvalid = 1'b0;
         end
         if (s_arvalid_in && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = `IPCB_RESP_OKAY;
            unique case (s_araddr_in[3:2])
               ctrl_addr[3:2]: nxt_st.rdata = word;
               status_addr[3:2]: nxt_st.rdata = {28'h0, st_ff.en};
               default: begin
                  nxt_st.rdata = 32'h0;
                  nxt_st.rresp = `IPCB_RESP_SLVERR;
               end
            endcase
         end else if (st_ff.rvalid && s_rready_in) begin
            nxt_st.rvalid = 1'b0;
         end
         for (int i = 0; i < `IPCB_NUM_SLOTS; i++) begin
            nxt_st.en[i] = (slots[i].level != `IPCB_LEVEL_RESET);
            nxt_st.lvl[i*3 +: 3] = slots[i].level;
            nxt_st.sub[i*2 +: 2] = slots[i].sublevel;
         end
         nxt_st.awready = !nxt_st.aw_held;
         nxt_st.wready = !nxt_st.w_held;
         nxt_st.arready = !nxt_st.rvalid;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= bus_rst;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_awready_out = st_ff.awready;
   assign s_wready_out = st_ff.wready;
   assign s_bvalid_out = st_ff.bvalid;
   assign s_bresp_out = st_ff.bresp;
   assign s_arready_out = st_ff.arready;
   assign s_rvalid_out = st_ff.rvalid;
   assign s_rdata_out = st_ff.rdata;
   assign s_rresp_out = st_ff.rresp;
   assign slot_enabled_out = st_ff.en;
   assign slot_level_out = st_ff.lvl;
   assign slot_sublevel_out = st_ff.sub;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b);

   AST_LEVEL_ZERO_DISABLES: assert property (
      ce_in |=> (st_ff.en == $past({slots[3].level != 3'h0, slots[2].level != 3'h0,
                                    slots[1].level != 3'h0, slots[0].level != 3'h0})))
      else $error("enable does not follow nonzero level");
   AST_SUBLEVEL_DIRECT: assert property (
      ce_in |=> (st_ff.sub == $past({slots[3].sublevel, slots[2].sublevel,
                                     slots[1].sublevel, slots[0].sublevel})))
      else $error("sublevel output differs from field");
   AST_UNUSED_ZERO: assert property (
      s_rvalid_out |-> (s_rdata_out & 32'he0e0e0e0) == 32'h0)
      else $error("unused bits read nonzero");
   AST_SLOT3_MAP: assert property (
      (ce_in && wr_go && wr_strb[3]) |=> ##1 slot_level_out[11:9] == $past(st_ff.wdata[28:26], 2)
         && slot_sublevel_out[7:6] == $past(st_ff.wdata[25:24], 2))
      else $error("slot three fields misplaced");
   AST_SLOT2_MAP: assert property (
      (ce_in && wr_go && wr_strb[2]) |=> word[20:16] == $past(st_ff.wdata[20:16]))
      else $error("slot two fields misplaced");
   AST_SLOT1_MAP: assert property (
      (ce_in && wr_go && wr_strb[1]) |=> word[12:8] == $past(st_ff.wdata[12:8]))
      else $error("slot one fields misplaced");
   AST_SLOT0_MAP: assert property (
      (ce_in && wr_go && wr_strb[0]) |=> word[7:0] == {3'h0, $past(st_ff.wdata[4:0])})
      else $error("slot zero fields misplaced");
   AST_RESET_ZERO: assert property (
      $rose(rst_b) |-> word == 32'h0 && st_ff.en == 4'h0)
      else $error("fields not zero after reset");
   AST_WRITE_RESP: assert property (
      (ce_in && wr_go) |=> s_bvalid_out)
      else $error("write gave no response");
   AST_READY_BACK: assert property (
      (ce_in && wr_go) |=> s_awready_out && s_wready_out)
      else $error("write channels not ready again after the write");
   AST_REFUSED_WRITE: assert property (
      (ce_in && wr_go && st_ff.awaddr[3:2] != ctrl_addr[3:2]) |=> $stable(word)
         && s_bresp_out == `IPCB_RESP_SLVERR)
      else $error("refused write changed the word or was not refused");
   AST_STATUS_READ: assert property (
      (ce_in && s_arvalid_in && s_arready_out && s_araddr_in[3:2] == status_addr[3:2])
         |=> s_rdata_out == {28'h0, $past(st_ff.en)})
      else $error("status read differs from slot enables");

   COV_WRITE: cover property (wr_go && wr_strb == 4'hf);
   COV_READ_CTRL: cover property (s_arvalid_in && s_arready_out && s_araddr_in == 4'h0);
   COV_ALL_ENABLED: cover property (slot_enabled_out == 4'hf);
   COV_BAD_ADDR: cover property (s_bvalid_out && s_bresp_out == 2'h2);
endmodule : ipcb_bank

//--- rtl/ipcb_params.svh
// constants for the interrupt priority control bank
`ifndef IPCB_PARAMS_SVH
`define IPCB_PARAMS_SVH
`define IPCB_CTRL_OFFSET 4'h0
`define IPCB_STATUS_OFFSET 4'h4
`define IPCB_NUM_SLOTS 4
`define IPCB_SLOT_STRIDE 8
`define IPCB_LEVEL_LSB 2
`define IPCB_SUBLEVEL_LSB 0
`define IPCB_LEVEL_RESET 3'h0
`define IPCB_SUBLEVEL_RESET 2'h0
`define IPCB_RESP_OKAY 2'h0
`define IPCB_RESP_SLVERR 2'h2
`endif

//--- rtl/ipcb_pkg.sv
// types for the interrupt priority control bank
package ipcb_pkg;
   typedef logic [2:0] ipcb_level_t;
   typedef logic [1:0] ipcb_sublevel_t;
   typedef struct packed {
      ipcb_level_t level;
      ipcb_sublevel_t sublevel;
   } ipcb_slot_s;
   typedef struct packed {
      logic awvalid;
      logic [3:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [3:0] araddr;
      logic rready;
   } ipcb_axi_req_s;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ipcb_axi_rsp_s;
endpackage : ipcb_pkg

//--- rtl/ipcb_slot_store.sv
// storage for the four slot fields of the priority control word
`timescale 1ns/1ns
`include "ipcb_params.svh"
module ipcb_slot_store
   import ipcb_pkg::*;
(
   // clock, reset and enable
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // write port
   input wire logic wr_en_in,
   input wire logic [31:0] wr_data_in,
   input wire logic [3:0] wr_strb_in,
   // read port
   output ipcb_slot_s [3:0] slots_out,
   output logic [31:0] rd_word_out
);
   typedef struct packed {
      ipcb_slot_s [3:0] slots;
      logic [31:0] word;
   } ipcb_store_s;

   ipcb_store_s state_ff;
   ipcb_store_s nxt_state;

   always_comb begin
      nxt_state = state_ff;
      if (ce_in) begin
         for (int i = 0; i < `IPCB_NUM_SLOTS; i++) begin
            if (wr_en_in && wr_strb_in[i]) begin
               nxt_state.slots[i].level =
                  wr_data_in[i*`IPCB_SLOT_STRIDE + `IPCB_LEVEL_LSB +: 3];
               nxt_state.slots[i].sublevel =
                  wr_data_in[i*`IPCB_SLOT_STRIDE + `IPCB_SUBLEVEL_LSB +: 2];
            end
         end
         for (int i = 0; i < `IPCB_NUM_SLOTS; i++) begin
            // upper three bits of each byte are not stored at all
            nxt_state.word[i*8 +: 8] = {3'h0, nxt_state.slots[i].level,
                                        nxt_state.slots[i].sublevel};
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign slots_out = state_ff.slots;
   assign rd_word_out = state_ff.word;
endmodule : ipcb_slot_store

//--- dv/ipcb_bank_bench.sv
// self-checking bench for the interrupt priority control bank
`timescale 1ns/1ns
`include "ipcb_params.svh"
module ipcb_bank_bench;
   logic mclk, rst_b, awv, wv, bready, arv, rready;
   logic [3:0] awa, ws, ara, slot_en;
   logic [31:0] wd, rdata, got;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [11:0] slot_lvl;
   logic [7:0] slot_sub;
   int failures, check_count;

   ipcb_bank u_ipcb_bank (.mclk_in(mclk), .rst_b_in(rst_b), .ce_in(1'b1),
      .s_awvalid_in(awv), .s_awaddr_in(awa), .s_wvalid_in(wv), .s_wdata_in(wd),
      .s_wstrb_in(ws), .s_bready_in(bready), .s_arvalid_in(arv), .s_araddr_in(ara),
      .s_rready_in(rready), .s_awready_out(awready), .s_wready_out(wready),
      .s_bvalid_out(bvalid), .s_bresp_out(bresp), .s_arready_out(arready),
      .s_rvalid_out(rvalid), .s_rdata_out(rdata), .s_rresp_out(rresp),
      .slot_enabled_out(slot_en), .slot_level_out(slot_lvl), .slot_sublevel_out(slot_sub));

   always #50 mclk = ~mclk;

   // ----------------------------------------
   // bus tasks and checks
   // ----------------------------------------
   task summarize;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task chk_resp(input logic [1:0] e);
      chk({30'h0, resp}, {30'h0, e});
   endtask : chk_resp

   // a stuck handshake ends the run instead of hanging it
   task bound(input int n);
      if (n == 50) begin
         failures++;
         summarize();
      end
   endtask : bound

   task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      bit done;
      n = 0;
      done = 0;
      @(posedge mclk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      ws <= s;
      bready <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         n++;
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            done = 1;
         end
         bound(n);
      end
      bready <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a);
      int n;
      bit done;
      n = 0;
      done = 0;
      @(posedge mclk);
      arv <= 1'b1;
      ara <= a;
      rready <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         n++;
         if (arready) arv <= 1'b0;
         if (rvalid) begin
            got = rdata;
            resp = rresp;
            done = 1;
         end
         bound(n);
      end
      rready <= 1'b0;
   endtask : rd

   // expected arbiter outputs {sublevels, enables, levels} from a word
   function automatic logic [31:0] slots_of(input logic [31:0] w);
      logic [31:0] r;
      r = 32'h0;
      for (int k = 0; k < 4; k++) begin
         r[16 + 2 * k +: 2] = w[8 * k +: 2];
         r[3 * k +: 3] = w[8 * k + 2 +: 3];
         r[12 + k] = |w[8 * k + 2 +: 3];
      end
      return r;
   endfunction : slots_of

   task verify(input logic [31:0] w);
      logic [31:0] e;
      e = slots_of(w);
      repeat (3) @(posedge mclk);
      chk({8'h0, slot_sub, slot_en, slot_lvl}, e);
      rd(4'h0);
      chk(got, w);
      chk_resp(`IPCB_RESP_OKAY);
      rd(4'h4);
      chk(got, {28'h0, e[15:12]});
   endtask : verify

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      mclk = 0;
      rst_b = 0;
      {awv, wv, bready, arv, rready} = 5'h00;
      {awa, ws, ara, wd} = 44'h0;
      failures = 0;
      check_count = 0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      verify(32'h0);
      wr(4'h0, 32'hffffffff, 4'hf);
      chk_resp(`IPCB_RESP_OKAY);
      verify(32'h1f1f1f1f);
      wr(4'h0, 32'hf6edf8e3, 4'hf);
      verify(32'h160d1803);
      wr(4'h0, 32'h0, 4'h2);
      verify(32'h160d0003);
      wr(4'h4, 32'hffffffff, 4'hf);
      chk_resp(`IPCB_RESP_SLVERR);
      wr(4'h8, 32'hffffffff, 4'hf);
      chk_resp(`IPCB_RESP_SLVERR);
      rd(4'hc);
      chk(got, 32'h0);
      chk_resp(`IPCB_RESP_SLVERR);
      verify(32'h160d0003);
      // every level and sublevel code on slot zero, with junk in the top bits
      for (int i = 0; i < 8; i++) begin
         wr(4'h0, {24'h0, 3'h7, i[2:0], i[1:0]}, 4'h1);
         verify({24'h160d00, 3'h0, i[2:0], i[1:0]});
      end
      rst_b <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      verify(32'h0);
      summarize();
   end
endmodule : ipcb_bank_bench
